/* File: ppd_map.vh */
// Register map and timing constants for the PHY port diagnostic block
// Functional notes
// - Writing one to bit 15 starts test; self-clears
// - Bit 15 reads one while test runs
// - Writing zero aborts test; resets to zero
// - Bits 13:12 select pair A to D
// - Bits 9:8 report normal, open, short, failed
// - Bits 7:0 give distance to fault
// - Link bits: 1 gigabit, 0 fast
// - Symbol error frame counter, clear on read
// - Bits 15:8 are event enables
// - Bits 7:0 are event flags
// - Flags read-only, cleared by reading
`ifndef PPD_MAP_VH
`define PPD_MAP_VH
`define PPD_ADDR_W 12
`define PPD_OFS_CABLE 12'h124
`define PPD_OFS_LINK 12'h126
`define PPD_OFS_SYMERR 12'h12A
`define PPD_OFS_EVENT 12'h136
`define PPD_OFS_IRQ_STAT 12'h140
`define PPD_OFS_IRQ_MASK 12'h142
`define PPD_BIT_TEST_RUN 15
`define PPD_PAIR_HI 13
`define PPD_PAIR_LO 12
`define PPD_COND_HI 9
`define PPD_COND_LO 8
`define PPD_DIST_HI 7
`define PPD_DIST_LO 0
`define PPD_EN_HI 15
`define PPD_EN_LO 8
`define PPD_FLAG_HI 7
`define PPD_FLAG_LO 0
`define PPD_RST_PAIR 2'h0
`define PPD_RST_COND 2'h0
`define PPD_RST_DIST 8'h00
`define PPD_RST_COUNT 16'h0000
`define PPD_RST_EVENT 8'h00
`define PPD_IRQ_TEST_DONE 0
`define PPD_IRQ_EVENT 1
`define PPD_IRQ_COUNT_WRAP 2
`define PPD_TEST_TIMEOUT_CYC 16'hFFFF
`endif

/* File: ppd_sync2.v */
// Two flip-flop synchroniser for a bus of levels
`timescale 1ns/10ps
`default_nettype none
module ppd_sync2 #(
    parameter WIDTH = 1
) (
    // Clock and reset
    input wire i_clock,
    input wire i_arst_n,
    // Data
    input wire [WIDTH-1:0] i_async,
    output reg [WIDTH-1:0] o_sync
);
    reg [WIDTH-1:0] meta_ff; // First stage, read only by second stage

    // Two stage capture
    always @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            meta_ff <= {WIDTH{1'b0}};
            o_sync <= {WIDTH{1'b0}};
        end
        else
        begin
            meta_ff <= i_async;
            o_sync <= meta_ff;
        end
    end
endmodule // ppd_sync2
`default_nettype wire

/* File: ppd_regs.v */
// Per-port cable test, link state, error count and event registers
`timescale 1ns/10ps
`default_nettype none
`include "ppd_map.vh"
module ppd_regs #(
    parameter TIMEOUT_CYC = `PPD_TEST_TIMEOUT_CYC
) (
    // Clock and reset
    input wire i_clock,
    input wire i_arst_n,
    // Register port
    input wire [`PPD_ADDR_W-1:0] i_addr,
    input wire [15:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [15:0] o_rdata_ff,
    // Cable measurement engine (same clock)
    output reg o_test_start_ff,
    output reg o_test_abort_ff,
    output reg [1:0] o_test_pair_ff,
    input wire i_test_done,
    input wire [1:0] i_test_cond,
    input wire [7:0] i_test_dist,
    // PHY status pins (asynchronous)
    input wire i_link_1000,
    input wire i_link_100,
    input wire i_symbol_error_frame,
    input wire [7:0] i_phy_events,
    // Interrupts
    output reg o_port_irq_ff,
    output reg o_irq_ff
);
    // Synchronised pin inputs
    wire [10:0] pin_sync;
    wire link_1000;
    wire link_100;
    wire sym_err;
    wire [7:0] ev_lvl;

    ppd_sync2 #(
        .WIDTH(11)
    ) u_sync (
        .i_clock(i_clock),
        .i_arst_n(i_arst_n),
        .i_async({i_link_1000, i_link_100, i_symbol_error_frame,
            i_phy_events}),
        .o_sync(pin_sync)
    );

    assign link_1000 = pin_sync[10];
    assign link_100 = pin_sync[9];
    assign sym_err = pin_sync[8];
    assign ev_lvl = pin_sync[7:0];

    // Edge detection on synchronised levels
    reg sym_err_d_ff; // Previous symbol error level
    reg [7:0] ev_d_ff; // Previous event levels
    wire sym_err_pulse;
    wire [7:0] ev_pulse;

    assign sym_err_pulse = sym_err & ~sym_err_d_ff;
    assign ev_pulse = ev_lvl & ~ev_d_ff;

    always @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            sym_err_d_ff <= 1'b0;
            ev_d_ff <= 8'h00;
        end
        else
        begin
            sym_err_d_ff <= sym_err;
            ev_d_ff <= ev_lvl;
        end
    end

    // Access decode
    wire wr_cable;
    wire wr_event;
    wire wr_mask;
    wire rd_symerr;
    wire rd_event;
    wire rd_stat;

    assign wr_cable = i_wr & (i_addr == `PPD_OFS_CABLE);
    assign wr_event = i_wr & (i_addr == `PPD_OFS_EVENT);
    assign wr_mask = i_wr & (i_addr == `PPD_OFS_IRQ_MASK);
    assign rd_symerr = i_rd & (i_addr == `PPD_OFS_SYMERR);
    assign rd_event = i_rd & (i_addr == `PPD_OFS_EVENT);
    assign rd_stat = i_rd & (i_addr == `PPD_OFS_IRQ_STAT);

    // Watchdog limit cut to the counter width on purpose
    localparam [31:0] TMO_WIDE = TIMEOUT_CYC;
    localparam [15:0] TMO_LAST = TMO_WIDE[15:0];

    // Cable test state
    localparam ST_IDLE = 1'b0; // No test running
    localparam ST_RUN = 1'b1; // Test in progress

    reg state_ff;
    reg nxt_state;
    reg [1:0] cond_ff; // Cable condition code
    reg [7:0] dist_ff; // Distance to fault
    reg [15:0] tmo_ff; // Watchdog on the engine
    reg test_done_evt; // Completion event for status
    reg nxt_start;
    reg nxt_abort;

    // Test sequencer next state
    always @*
    begin
        nxt_state = state_ff;
        nxt_start = 1'b0;
        nxt_abort = 1'b0;
        test_done_evt = 1'b0;
        case (state_ff)
            ST_IDLE:
            begin
                // Writing one starts the test
                if (wr_cable && i_wdata[`PPD_BIT_TEST_RUN])
                begin
                    nxt_state = ST_RUN;
                    nxt_start = 1'b1;
                end
            end
            ST_RUN:
            begin
                // Writing zero disables the test
                if (wr_cable && !i_wdata[`PPD_BIT_TEST_RUN])
                begin
                    nxt_state = ST_IDLE;
                    nxt_abort = 1'b1;
                end
                // Completion or watchdog expiry self-clears the bit
                else if (i_test_done || tmo_ff == TMO_LAST)
                begin
                    nxt_state = ST_IDLE;
                    test_done_evt = 1'b1;
                end
            end
            default:
            begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    // Test sequencer registers and results
    always @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            state_ff <= ST_IDLE;
            o_test_start_ff <= 1'b0;
            o_test_abort_ff <= 1'b0;
            o_test_pair_ff <= `PPD_RST_PAIR;
            cond_ff <= `PPD_RST_COND;
            dist_ff <= `PPD_RST_DIST;
            tmo_ff <= 16'h0000;
        end
        else
        begin
            state_ff <= nxt_state;
            o_test_start_ff <= nxt_start;
            o_test_abort_ff <= nxt_abort;
            // Pair select is writable; software keeps it during a test
            if (wr_cable)
            begin
                o_test_pair_ff <= i_wdata[`PPD_PAIR_HI:`PPD_PAIR_LO];
            end
            // Watchdog counts only while running
            if (state_ff == ST_RUN)
            begin
                tmo_ff <= tmo_ff + 16'h0001;
            end
            else
            begin
                tmo_ff <= 16'h0000;
            end
            // Latch results; a timeout reports test failed
            if (test_done_evt)
            begin
                if (i_test_done)
                begin
                    cond_ff <= i_test_cond;
                    dist_ff <= i_test_dist;
                end
                else
                begin
                    cond_ff <= 2'h3;
                    dist_ff <= `PPD_RST_DIST;
                end
            end
        end
    end

    // Symbol error frame counter, saturating, clear on read
    reg [15:0] symerr_cnt_ff;
    wire cnt_full;

    assign cnt_full = (symerr_cnt_ff == 16'hFFFF);

    always @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            symerr_cnt_ff <= `PPD_RST_COUNT;
        end
        else if (rd_symerr)
        begin
            // A frame in the read cycle is counted, not lost
            symerr_cnt_ff <= {15'h0000, sym_err_pulse};
        end
        else if (sym_err_pulse && !cnt_full)
        begin
            symerr_cnt_ff <= symerr_cnt_ff + 16'h0001;
        end
    end

    // Event enables and sticky flags
    reg [7:0] ev_en_ff; // Enables, jabber at top
    reg [7:0] ev_flag_ff; // Flags, jabber at top

    always @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            ev_en_ff <= `PPD_RST_EVENT;
            ev_flag_ff <= `PPD_RST_EVENT;
        end
        else
        begin
            if (wr_event)
            begin
                ev_en_ff <= i_wdata[`PPD_EN_HI:`PPD_EN_LO];
            end
            // Read clears, new events win over the clear
            if (rd_event)
            begin
                ev_flag_ff <= ev_pulse;
            end
            else
            begin
                ev_flag_ff <= ev_flag_ff | ev_pulse;
            end
        end
    end

    // Block interrupt status and mask
    reg [2:0] irq_stat_ff; // Sticky block events
    reg [2:0] irq_mask_ff; // One enables the matching bit
    wire [2:0] irq_set;

    assign irq_set = {sym_err_pulse & cnt_full, |ev_pulse, test_done_evt};

    always @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            irq_stat_ff <= 3'h0;
            irq_mask_ff <= 3'h0;
        end
        else
        begin
            if (wr_mask)
            begin
                irq_mask_ff <= i_wdata[2:0];
            end
            // Set wins over the read clear
            if (rd_stat)
            begin
                irq_stat_ff <= irq_set;
            end
            else
            begin
                irq_stat_ff <= irq_stat_ff | irq_set;
            end
        end
    end

    // Interrupt outputs, one cycle after the flags
    always @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_port_irq_ff <= 1'b0;
            o_irq_ff <= 1'b0;
        end
        else
        begin
            o_port_irq_ff <= |(ev_flag_ff & ev_en_ff);
            o_irq_ff <= |(irq_stat_ff & irq_mask_ff);
        end
    end

    // Read data mux
    reg [15:0] nxt_rdata;

    always @*
    begin
        nxt_rdata = 16'h0000;
        case (i_addr)
            `PPD_OFS_CABLE:
            begin
                nxt_rdata = {state_ff, 1'b0, o_test_pair_ff, 2'h0,
                    cond_ff, dist_ff};
            end
            `PPD_OFS_LINK:
            begin
                nxt_rdata = {14'h0000, link_1000, link_100};
            end
            `PPD_OFS_SYMERR:
            begin
                nxt_rdata = symerr_cnt_ff;
            end
            `PPD_OFS_EVENT:
            begin
                nxt_rdata = {ev_en_ff, ev_flag_ff};
            end
            `PPD_OFS_IRQ_STAT:
            begin
                nxt_rdata = {13'h0000, irq_stat_ff};
            end
            `PPD_OFS_IRQ_MASK:
            begin
                nxt_rdata = {13'h0000, irq_mask_ff};
            end
            default:
            begin
                nxt_rdata = 16'h0000; // Unmapped reads as zero
            end
        endcase
    end

    // Read data register, valid only the cycle after a read
    always @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_rdata_ff <= 16'h0000;
        end
        else if (i_rd)
        begin
            o_rdata_ff <= nxt_rdata;
        end
        else
        begin
            o_rdata_ff <= 16'h0000;
        end
    end
endmodule // ppd_regs
`default_nettype wire

/* File: ppd_regs_sva.sv */
// Checker for the PHY port diagnostic register block
`timescale 1ns/10ps
`default_nettype none
`include "ppd_map.vh"
module ppd_regs_sva #(
    parameter TIMEOUT_CYC = `PPD_TEST_TIMEOUT_CYC
) (
    // Clock and reset
    input wire i_clock,
    input wire i_arst_n,
    // Register port
    input wire [`PPD_ADDR_W-1:0] i_addr,
    input wire [15:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    input wire [15:0] o_rdata_ff,
    // Engine and interrupt
    input wire o_test_start_ff,
    input wire o_test_abort_ff,
    input wire [1:0] o_test_pair_ff,
    input wire i_test_done,
    input wire o_port_irq_ff
);
    // Write to the cable test register
    wire wr_cab;
    reg run_ff; // Test running as software sees it
    reg [15:0] tmo_ff; // Cycles spent running

    assign wr_cab = i_wr && (i_addr == `PPD_OFS_CABLE);

    // Track running state, watchdog expiry included
    always @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            run_ff <= 1'b0;
            tmo_ff <= 16'h0000;
        end
        else
        begin
            tmo_ff <= run_ff ? tmo_ff + 16'h0001 : 16'h0000;
            // Start only from idle; zero aborts; done or expiry ends
            if (wr_cab && !run_ff)
                run_ff <= i_wdata[15];
            else if (wr_cab && !i_wdata[15])
                run_ff <= 1'b0;
            else if (i_test_done || tmo_ff == TIMEOUT_CYC)
                run_ff <= 1'b0;
        end
    end

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_arst_n);
    chk_start_cause: assert property ($rose(o_test_start_ff) |->
        $past(wr_cab && i_wdata[15] && !run_ff)) else $error("bad start");
    chk_start_pulse: assert property (o_test_start_ff |=>
        !o_test_start_ff) else $error("start too long");
    chk_busy_read: assert property ($past(i_rd) &&
        $past(i_addr) == `PPD_OFS_CABLE |-> o_rdata_ff[15] == $past(run_ff))
        else $error("busy bit wrong");
    chk_abort_cause: assert property (o_test_abort_ff |->
        $past(wr_cab && !i_wdata[15] && run_ff)) else $error("bad abort");
    chk_pair_write: assert property (!$stable(o_test_pair_ff) |->
        $past(wr_cab) && o_test_pair_ff == $past(i_wdata[13:12]))
        else $error("pair changed");
    chk_pair_read: assert property ($past(i_rd) &&
        $past(i_addr) == `PPD_OFS_CABLE |->
        o_rdata_ff[13:12] == o_test_pair_ff) else $error("pair read wrong");
    chk_link_resv: assert property ($past(i_rd) &&
        $past(i_addr) == `PPD_OFS_LINK |-> o_rdata_ff[15:2] == 14'h0000)
        else $error("link upper bits set");
    chk_event_irq: assert property ($past(i_rd) &&
        $past(i_addr) == `PPD_OFS_EVENT |->
        o_port_irq_ff == |(o_rdata_ff[15:8] & o_rdata_ff[7:0]))
        else $error("port irq wrong");
    chk_en_write: assert property (i_wr &&
        i_addr == `PPD_OFS_EVENT ##1 i_rd && i_addr == `PPD_OFS_EVENT |=>
        o_rdata_ff[15:8] == $past(i_wdata[15:8], 2))
        else $error("enable lost");
endmodule // ppd_regs_sva
bind ppd_regs ppd_regs_sva #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_chk (.i_clock,
    .i_arst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata_ff, .o_test_start_ff,
    .o_test_abort_ff, .o_test_pair_ff, .i_test_done, .o_port_irq_ff);
`default_nettype wire

/* File: ppd_regs_bench.sv */
// Self-checking bench for the PHY port diagnostic registers
`timescale 1ns/10ps
`default_nettype none
`include "ppd_map.vh"
module ppd_regs_bench;
    logic i_clock = 1'b0, i_arst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
    logic i_test_done = 1'b0, i_link_1000 = 1'b0, i_link_100 = 1'b0;
    logic i_symbol_error_frame = 1'b0, o_test_start_ff, o_test_abort_ff;
    logic o_port_irq_ff, o_irq_ff;
    logic [11:0] i_addr = 12'h000;
    logic [15:0] i_wdata = 16'h0000, o_rdata_ff, d;
    logic [1:0] i_test_cond = 2'h0, o_test_pair_ff, pp;
    logic [7:0] i_test_dist = 8'h00, i_phy_events = 8'h00;
    logic [9:0] res = 10'h000; // Last latched condition and distance
    int num_errors = 0, num_checks = 0, cyc = 0;
    ppd_regs #(.TIMEOUT_CYC(400)) DUT (.i_clock, .i_arst_n, .i_addr, .i_wdata,
        .i_wr, .i_rd, .o_rdata_ff, .o_test_start_ff, .o_test_abort_ff,
        .o_test_pair_ff, .i_test_done, .i_test_cond, .i_test_dist, .i_link_1000,
        .i_link_100, .i_symbol_error_frame, .i_phy_events, .o_port_irq_ff,
        .o_irq_ff);
    initial forever #10 i_clock = ~i_clock;
    // Hang guard
    always @(posedge i_clock)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            num_errors++;
            final_report;
        end
    end
    task final_report;
        if (num_errors == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task chk(input string nm, input logic [15:0] s, e);
        num_checks++;
        if (s !== e)
        begin
            num_errors++;
            $display("wrong value %s exp %h seen %h", nm, e, s);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge i_clock);
    endtask
    // Bus cycles, entered just after a rising edge
    task wr(input logic [11:0] a, input logic [15:0] v);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= v;
        tick(1);
        i_wr <= 1'b0;
    endtask
    task rc(input string nm, input logic [11:0] a, input logic [15:0] e);
        i_rd <= 1'b1;
        i_addr <= a;
        tick(1);
        i_rd <= 1'b0;
        // Read data stand in this cycle only
        @(negedge i_clock);
        chk(nm, o_rdata_ff, e);
        tick(1);
    endtask
    task t_reset;
        rc("cable", `PPD_OFS_CABLE, 16'h0000);
        rc("count", `PPD_OFS_SYMERR, 16'h0000);
        rc("event", `PPD_OFS_EVENT, 16'h0000);
        rc("link", `PPD_OFS_LINK, 16'h0000);
    endtask
    // Every pair and condition code, then abort, stray done, watchdog
    task t_cable;
        for (int p = 0; p < 4; p++)
        begin
            pp = p[1:0];
            wr(`PPD_OFS_CABLE, {2'b10, pp, 12'h000});
            @(negedge i_clock);
            chk("start", {15'h0, o_test_start_ff}, 16'h0001);
            chk("pair", {14'h0, o_test_pair_ff}, {14'h0, pp});
            tick(1);
            rc("busy", `PPD_OFS_CABLE, {2'b10, pp, 2'b00, res});
            i_test_done <= 1'b1;
            i_test_cond <= pp;
            i_test_dist <= {6'h28, pp};
            tick(1);
            i_test_done <= 1'b0;
            i_test_cond <= ~pp;
            i_test_dist <= 8'h55;
            res = {pp, 6'h28, pp};
            // Results read only once the run bit has cleared
            d = {2'b00, pp, 2'b00, res};
            rc("done", `PPD_OFS_CABLE, d);
        end
        wr(`PPD_OFS_CABLE, 16'h9000);
        @(negedge i_clock);
        chk("start", {15'h0, o_test_start_ff}, 16'h0001);
        tick(1);
        wr(`PPD_OFS_CABLE, 16'h1000);
        @(negedge i_clock);
        chk("abort", {15'h0, o_test_abort_ff}, 16'h0001);
        tick(1);
        rc("abort", `PPD_OFS_CABLE, {6'h04, res});
        i_test_done <= 1'b1;
        tick(1);
        i_test_done <= 1'b0;
        rc("idle", `PPD_OFS_CABLE, {6'h04, res});
        // Engine never answers: watchdog ends the test as failed
        wr(`PPD_OFS_CABLE, 16'hB000);
        tick(410);
        rc("timeout", `PPD_OFS_CABLE, 16'h3300);
    endtask
    task t_link;
        i_link_1000 <= 1'b1;
        tick(4);
        rc("link", `PPD_OFS_LINK, 16'h0002);
        i_link_1000 <= 1'b0;
        i_link_100 <= 1'b1;
        tick(4);
        rc("link", `PPD_OFS_LINK, 16'h0001);
    endtask
    task t_count;
        repeat (3)
        begin
            i_symbol_error_frame <= 1'b1;
            tick(3);
            i_symbol_error_frame <= 1'b0;
            tick(3);
        end
        tick(3);
        rc("count", `PPD_OFS_SYMERR, 16'h0003);
        rc("count", `PPD_OFS_SYMERR, 16'h0000);
    endtask
    // Each event in turn, only link up enabled
    task t_event;
        wr(`PPD_OFS_IRQ_MASK, 16'h0002);
        tick(1);
        wr(`PPD_OFS_EVENT, 16'h0100);
        rc("enables", `PPD_OFS_EVENT, 16'h0100);
        rc("status", `PPD_OFS_IRQ_STAT, 16'h0001);
        for (int i = 0; i < 8; i++)
        begin
            i_phy_events <= 8'h01 << i;
            tick(6);
            d = {15'h0, i == 0};
            chk("port_irq", {15'h0, o_port_irq_ff}, d);
            chk("irq", {15'h0, o_irq_ff}, 16'h0001);
            rc("flags", `PPD_OFS_EVENT, {8'h01, 8'h01 << i});
            rc("cleared", `PPD_OFS_EVENT, 16'h0100);
            rc("status", `PPD_OFS_IRQ_STAT, 16'h0002);
            // Interrupts fall one cycle after the clearing read
            @(negedge i_clock);
            chk("irq", {15'h0, o_irq_ff}, 16'h0000);
            chk("port_irq", {15'h0, o_port_irq_ff}, 16'h0000);
            tick(1);
            i_phy_events <= 8'h00;
            tick(1);
        end
        wr(`PPD_OFS_IRQ_MASK, 16'h0000);
        i_phy_events <= 8'h80;
        tick(6);
        chk("masked", {15'h0, o_irq_ff}, 16'h0000);
        chk("port_irq", {15'h0, o_port_irq_ff}, 16'h0000);
        rc("flags", `PPD_OFS_EVENT, 16'h0180);
    endtask
    initial
    begin
        tick(8);
        i_arst_n <= 1'b1;
        tick(1);
        t_reset;
        t_cable;
        t_link;
        t_count;
        t_event;
        final_report;
    end
endmodule // ppd_regs_bench
`default_nettype wire
